// ---- core/pcr_cfg.svh ----
`ifndef PCR_CFG_SVH
`define PCR_CFG_SVH

// ---------------------------------------------------------------
// strap codes and multiples
// ---------------------------------------------------------------
`define PCR_STRAP_W 4
`define PCR_MULT_W 5
`define PCR_MULT_RSVD 5'h00
`define PCR_CODE_16 4'h0
`define PCR_CODE_2 4'h2
`define PCR_CODE_3 4'h3
`define PCR_CODE_4 4'h4
`define PCR_CODE_5 4'h5
`define PCR_CODE_6 4'h6
`define PCR_CODE_8 4'h8
`define PCR_CODE_9 4'h9
`define PCR_CODE_10 4'ha
`define PCR_CODE_12 4'hc
`define PCR_CODE_20 4'hd
`define PCR_MULT_16 5'h10
`define PCR_MULT_2 5'h02
`define PCR_MULT_3 5'h03
`define PCR_MULT_4 5'h04
`define PCR_MULT_5 5'h05
`define PCR_MULT_6 5'h06
`define PCR_MULT_8 5'h08
`define PCR_MULT_9 5'h09
`define PCR_MULT_10 5'h0a
`define PCR_MULT_12 5'h0c
`define PCR_MULT_20 5'h14
// reserved codes select no multiple
`define PCR_RSVD_1 4'h1
`define PCR_RSVD_7 4'h7
`define PCR_RSVD_11 4'hb
`define PCR_RSVD_14 4'he
`define PCR_RSVD_15 4'hf
// smallest and largest valid multiple
`define PCR_MULT_MIN 5'h02
`define PCR_MULT_MAX 5'h14

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
// cycles after reset release before the strap is sampled (settling)
`define PCR_SETTLE_CYC 4'h4
// memory clock is platform clock divided by this
`define PCR_MEM_DIV 2

`endif

// ---- core/pcr_pkg.sv ----
`default_nettype none
package pcr_pkg;
   typedef logic [3:0] pcr_strap_t;
   typedef logic [4:0] pcr_mult_t;
   typedef enum logic [2:0] {
      PCR_SETTLE = 3'b001,
      PCR_RUN = 3'b010,
      PCR_ERROR = 3'b100
   } pcr_state_t;
endpackage
`default_nettype wire

// ---- core/pcr_phase_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pcr_cfg.svh"

// ---------------------------------------------------------------
// platform / memory clock tick counter
// ---------------------------------------------------------------
// models the platform clock as a phase accumulator on ref_clk:
// each ref cycle contributes mult platform ticks; one enable per tick
// is not possible at one clock, so plat_ticks_r keeps a running count of ticks, wrapping at 256.
module pcr_phase_gen (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire pcr_pkg::pcr_mult_t mult,
   output logic [7:0] plat_ticks_r,
   output logic [7:0] mem_ticks_r,
   output logic mem_half_r
);
   import pcr_pkg::*;

   logic [7:0] plat_nxt;

   always_comb begin
      plat_nxt = run ? 8'(plat_ticks_r + {3'h0, mult}) : plat_ticks_r;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         plat_ticks_r <= 8'h00;
         mem_ticks_r <= 8'h00;
         mem_half_r <= 1'b0;
      end else if (run) begin
         plat_ticks_r <= plat_nxt;
         // memory clock ticks once for every two platform ticks
         mem_ticks_r <= plat_nxt / 8'(`PCR_MEM_DIV);
         mem_half_r <= plat_nxt[0];
      end
   end
endmodule
`default_nettype wire

// ---- core/pcr_top.sv ----
// Summary of operation
// - decode four-bit strap into platform multiple
// - capture strap at reset, hold until next
// - platform clock equals reference times multiple
// - memory clock runs at half platform
`timescale 1ns/100ps
`default_nettype none
`include "pcr_cfg.svh"

module pcr_top #(
   parameter int SETTLE_CYC = `PCR_SETTLE_CYC
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire pcr_pkg::pcr_strap_t platform_ratio_strap,
   output pcr_pkg::pcr_mult_t ratio_mult_r,
   output logic ratio_valid_r,
   output logic cfg_error_r,
   output logic platform_clock_run_r,
   output logic [7:0] platform_ticks_r,
   output logic [7:0] memory_ticks_r
);
   import pcr_pkg::*;

   // ---------------------------------------------------------------
   // parameter checks
   // ---------------------------------------------------------------
   // the settle counter is four bits wide and must reach the capture count
   if (SETTLE_CYC < 1 || SETTLE_CYC > 15) begin
      $error("SETTLE_CYC must lie between 1 and 15");
   end

   // last cycle after the internal release by which a capture must show
   localparam int CAPTURE_LAST = SETTLE_CYC + 2;

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   logic rst_s1_r;
   logic rst_n_r;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   function automatic pcr_mult_t pcr_decode(input pcr_strap_t code);
      case (code)
         `PCR_CODE_16: pcr_decode = `PCR_MULT_16;
         `PCR_CODE_2: pcr_decode = `PCR_MULT_2;
         `PCR_CODE_3: pcr_decode = `PCR_MULT_3;
         `PCR_CODE_4: pcr_decode = `PCR_MULT_4;
         `PCR_CODE_5: pcr_decode = `PCR_MULT_5;
         `PCR_CODE_6: pcr_decode = `PCR_MULT_6;
         `PCR_CODE_8: pcr_decode = `PCR_MULT_8;
         `PCR_CODE_9: pcr_decode = `PCR_MULT_9;
         `PCR_CODE_10: pcr_decode = `PCR_MULT_10;
         `PCR_CODE_12: pcr_decode = `PCR_MULT_12;
         `PCR_CODE_20: pcr_decode = `PCR_MULT_20;
         default: pcr_decode = `PCR_MULT_RSVD; // reserved codes
      endcase
   endfunction

   // ---------------------------------------------------------------
   // capture sequence
   // ---------------------------------------------------------------
   // the strap is sampled once, a few cycles after reset release, so the
   // board's pulls have settled; nothing re-samples until arst_n falls again.
   pcr_state_t state_r;
   logic [3:0] settle_r;
   pcr_mult_t dec_mult;
   logic capture_now;

   assign dec_mult = pcr_decode(platform_ratio_strap);
   // one-cycle strobe on the single edge at which the strap is taken
   assign capture_now = (state_r == PCR_SETTLE) && (settle_r == 4'(SETTLE_CYC - 1));

   always_ff @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         settle_r <= 4'h0;
      end else if (state_r == PCR_SETTLE) begin
         settle_r <= settle_r + 4'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= PCR_SETTLE;
         ratio_mult_r <= `PCR_MULT_RSVD;
         ratio_valid_r <= 1'b0;
         cfg_error_r <= 1'b0;
         platform_clock_run_r <= 1'b0;
      end else begin
         case (state_r)
            PCR_SETTLE: begin
               if (capture_now) begin
                  ratio_mult_r <= dec_mult;
                  if (dec_mult == `PCR_MULT_RSVD) begin
                     state_r <= PCR_ERROR;
                     cfg_error_r <= 1'b1;
                  end else begin
                     state_r <= PCR_RUN;
                     ratio_valid_r <= 1'b1;
                     platform_clock_run_r <= 1'b1;
                  end
               end
            end
            PCR_RUN: state_r <= PCR_RUN; // held until next reset
            PCR_ERROR: state_r <= PCR_ERROR;
            default: state_r <= PCR_ERROR;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // clock rate model
   // ---------------------------------------------------------------
   pcr_phase_gen pcr_phase_gen_inst (
      .clk(ref_clk),
      .rst_n(rst_n_r),
      .run(platform_clock_run_r),
      .mult(ratio_mult_r),
      .plat_ticks_r(platform_ticks_r),
      .mem_ticks_r(memory_ticks_r),
      .mem_half_r()
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_ratio_held: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      (ratio_valid_r || cfg_error_r) |=> $stable(ratio_mult_r))
      else $error("captured ratio changed");
   a_error_no_clock: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      cfg_error_r |-> !platform_clock_run_r && !ratio_valid_r)
      else $error("clock running on reserved code");
   a_decode_match: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      $rose(ratio_valid_r) |-> ratio_mult_r == $past(dec_mult) && ratio_mult_r != 5'd0)
      else $error("decoded multiple wrong");
   a_plat_rate: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      platform_clock_run_r && $past(platform_clock_run_r)
      |=> platform_ticks_r == 8'($past(platform_ticks_r) + {3'h0, ratio_mult_r}))
      else $error("platform tick rate wrong");
   a_mem_half: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      memory_ticks_r == platform_ticks_r / 8'h02 || !platform_clock_run_r
      || !$past(platform_clock_run_r))
      else $error("memory clock not half platform");
   a_capture_time: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      $rose(rst_n_r) |-> ##[1:CAPTURE_LAST] (ratio_valid_r || cfg_error_r))
      else $error("strap not captured in time");

   // ---------------------------------------------------------------
   // checks on capture timing and hold
   // ---------------------------------------------------------------
   // a late resample would let a board glitch move the clock after boot
   a_no_early_capture: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      (state_r == PCR_SETTLE) && !capture_now
      |=> (state_r == PCR_SETTLE) && !ratio_valid_r && !cfg_error_r)
      else $error("strap taken before the settle count");
   a_capture_once: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      $rose(ratio_valid_r || cfg_error_r) |-> $past(capture_now))
      else $error("capture outcome set off the capture edge");
   a_flags_held: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      ratio_valid_r || cfg_error_r |=> $stable({ratio_valid_r, cfg_error_r, platform_clock_run_r}))
      else $error("capture outcome changed before reset");
   a_settle_bound: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      settle_r <= 4'(SETTLE_CYC))
      else $error("settle counter ran past the capture count");
   a_state_onehot: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      $onehot(state_r))
      else $error("capture state not one-hot");

   // ---------------------------------------------------------------
   // checks on the decoded multiple
   // ---------------------------------------------------------------
   // most codes encode their own multiple, so this check needs no table
   a_decode_same: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      capture_now && (platform_ratio_strap inside {`PCR_CODE_2, `PCR_CODE_3, `PCR_CODE_4, `PCR_CODE_5,
      `PCR_CODE_6, `PCR_CODE_8, `PCR_CODE_9, `PCR_CODE_10, `PCR_CODE_12})
      |=> ratio_valid_r && ratio_mult_r == {1'b0, $past(platform_ratio_strap)})
      else $error("self-coded multiple wrong");
   a_decode_sixteen: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      capture_now && platform_ratio_strap == `PCR_CODE_16
      |=> ratio_valid_r && ratio_mult_r == `PCR_MULT_16)
      else $error("multiple sixteen wrong");
   a_decode_twenty: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      capture_now && platform_ratio_strap == `PCR_CODE_20
      |=> ratio_valid_r && ratio_mult_r == `PCR_MULT_20)
      else $error("multiple twenty wrong");
   a_mult_range: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      ratio_valid_r |-> ratio_mult_r >= `PCR_MULT_MIN && ratio_mult_r <= `PCR_MULT_MAX)
      else $error("valid multiple out of range");
   a_reserved_flag: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      capture_now && (platform_ratio_strap inside {`PCR_RSVD_1, `PCR_RSVD_7, `PCR_RSVD_11, `PCR_RSVD_14,
      `PCR_RSVD_15}) |=> cfg_error_r && !ratio_valid_r && ratio_mult_r == `PCR_MULT_RSVD)
      else $error("reserved code not flagged");
   a_flags_excl: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      !(ratio_valid_r && cfg_error_r))
      else $error("valid and error both set");

   // ---------------------------------------------------------------
   // checks on the clock rate model
   // ---------------------------------------------------------------
   // the platform counter wraps at 256, the memory counter (half of it) at 128; the checks compare modulo 256
   a_run_follows: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      platform_clock_run_r == ratio_valid_r)
      else $error("platform clock run differs from valid capture");
   a_ticks_idle: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      !platform_clock_run_r |-> platform_ticks_r == 8'h00 && memory_ticks_r == 8'h00)
      else $error("ticks counted without a valid ratio");
   a_mem_step: assert property (@(posedge ref_clk) disable iff (!rst_n_r)
      platform_clock_run_r && $past(platform_clock_run_r)
      |=> memory_ticks_r == (8'($past(platform_ticks_r) + {3'h0, ratio_mult_r}) >> 1))
      else $error("memory tick step wrong");
endmodule
`default_nettype wire

// ---- test/pcr_strap_drv.sv ----
`timescale 1ns/100ps
`default_nettype none
module pcr_strap_drv (
   input wire logic clk,
   input wire logic arst_n,
   input wire pcr_pkg::pcr_strap_t code,
   output pcr_pkg::pcr_strap_t strap
);
   import pcr_pkg::*;
   logic [3:0] cnt_r = 4'h0;
   logic tog_r = 1'b0;
   always @(negedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= 4'h0;
      end else if (cnt_r != 4'hf) begin
         cnt_r <= cnt_r + 4'h1;
      end
      tog_r <= ~tog_r;
   end
   // pins driven through capture reserved only when commanded
   // afterwards they wander so a late resample shows up
   assign strap = (cnt_r != 4'hf) ? code : (tog_r ? ~code : code ^ 4'h5);
endmodule
`default_nettype wire

// ---- test/platform_clock_ratio_strap_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module platform_clock_ratio_strap_bench;
   import pcr_pkg::*;
   logic ref_clk, arst_n;
   pcr_strap_t code, strap;
   pcr_mult_t ratio_mult_r;
   logic ratio_valid_r, cfg_error_r, platform_clock_run_r;
   logic [7:0] platform_ticks_r, memory_ticks_r;
   int n_mismatch = 0;
   int check_count = 0;
   // ---------------------------------------------------------------
   // multiple per strap code, zero marks a reserved code
   // ---------------------------------------------------------------
   localparam logic [7:0] MULT_TAB [16] = '{8'h10, 8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h00,
      8'h08, 8'h09, 8'h0a, 8'h00, 8'h0c, 8'h14, 8'h00, 8'h00};
   pcr_strap_drv pcr_strap_drv_inst (.clk(ref_clk), .arst_n(arst_n), .code(code), .strap(strap));
   pcr_top pcr_top_inst (.ref_clk(ref_clk), .arst_n(arst_n), .platform_ratio_strap(strap),
      .ratio_mult_r(ratio_mult_r), .ratio_valid_r(ratio_valid_r), .cfg_error_r(cfg_error_r),
      .platform_clock_run_r(platform_clock_run_r), .platform_ticks_r(platform_ticks_r),
      .memory_ticks_r(memory_ticks_r));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // one power-up with a given strap, then a run of 20 ref cycles
   // ---------------------------------------------------------------
   task automatic try_code(pcr_strap_t c);
      logic [7:0] m, p0;
      m = MULT_TAB[c];
      @(negedge ref_clk);
      arst_n = 1'b0;
      code = c;
      repeat (12) @(negedge ref_clk);
      check("mult in reset", {3'h0, ratio_mult_r}, 8'h00);
      check("run in reset", {7'h0, platform_clock_run_r}, 8'h00);
      arst_n = 1'b1;
      repeat (12) @(negedge ref_clk);
      check("mult", {3'h0, ratio_mult_r}, m);
      check("valid", {7'h0, ratio_valid_r}, {7'h0, m != 8'h00});
      check("error", {7'h0, cfg_error_r}, {7'h0, m == 8'h00});
      check("run", {7'h0, platform_clock_run_r}, {7'h0, m != 8'h00});
      p0 = platform_ticks_r;
      if (m == 8'h00) check("ticks", p0, 8'h00);
      repeat (20) @(negedge ref_clk);
      check("mult held", {3'h0, ratio_mult_r}, m);
      check("platform", platform_ticks_r, p0 + 8'(20 * m));
      check("memory", memory_ticks_r, (p0 + 8'(20 * m)) >> 1);
   endtask
   task automatic test_valid_codes();
      for (int i = 0; i < 16; i++) begin
         if (MULT_TAB[i] != 8'h00) try_code(4'(i));
      end
   endtask
   // error then valid again proves the error clears on the next power-up
   task automatic test_reserved_codes();
      for (int i = 15; i >= 0; i--) begin
         if (MULT_TAB[i] == 8'h00) try_code(4'(i));
      end
      try_code(4'hd); // 20 MHz times 20: 400 MHz platform, 200 MHz memory clock
   endtask
   initial begin
      arst_n = 1'b0;
      code = 4'h0;
      test_valid_codes();
      test_reserved_codes();
      test_done();
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      n_mismatch++;
      test_done();
   end
endmodule
`default_nettype wire
